// ==== sdcp_defines.vh ====
/*
  shared constants for the serial dac command port: command codes, field positions,
  reset values and apb register offsets. assumes inclusion by bare name from the design file.
*/
`ifndef SDCP_DEFINES_VH
`define SDCP_DEFINES_VH

`define SDCP_WORD_BITS      16
`define SDCP_CMD_MSB        15
`define SDCP_CMD_LSB        12
`define SDCP_DATA_MSB       11
`define SDCP_DATA_LSB       0

`define SDCP_CMD_NOP        4'h0
`define SDCP_CMD_LOAD       4'h1
`define SDCP_CMD_READBACK   4'h2
`define SDCP_CMD_CHAIN_OFF  4'h9
`define SDCP_CMD_RISE_EDGE  4'hA
`define SDCP_CMD_CLR_ZERO   4'hB
`define SDCP_CMD_CLR_MID    4'hC

`define SDCP_RST_DAC        12'h000
`define SDCP_MID_DAC        12'h800
`define SDCP_RST_SHIFT      16'h0000

`define SDCP_APB_CTRL       12'h000
`define SDCP_APB_STATUS     12'h004
`define SDCP_APB_DAC        12'h008
`define SDCP_APB_SHIFT      12'h00C

`endif

// ==== sdcp_top.v ====
/*
  serial command front end of a multiplying dac: frame select, shift clock and serial
  data from a host, chain output to the next device, dac code out, plus an apb slave
  for observing and steering the block. the pins arrive asynchronously and are
  sampled on pclk through two flip-flops; pclk must run several times the link clock.
*/
// Local design decisions: the register offsets and the APB interface to the registers.
module sdcp_top #(
  parameter DAC_BITS = 12
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        frame_n,
  input  wire        shift_clk,
  input  wire        serial_in,
  output reg         chain_data_out,
  output reg  [11:0] dac_code,
  output reg         dac_update,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr
);
`include "sdcp_defines.vh"

  localparam [11:0] DATA_MASK = ~((12'h001 << (12 - DAC_BITS)) - 12'h001);

  reg  [2:0]  fs_sync_q;
  reg  [2:0]  ck_sync_q;
  reg  [1:0]  di_sync_q;
  reg         rise_edge_q;
  reg         chain_en_q;
  reg  [15:0] shift_q;
  reg  [4:0]  count_q;
  reg         done_q;
  reg  [11:0] dac_q;
  reg         aborts_q;
  reg         sw_hold_q;

  wire frame_low  = ~fs_sync_q[1];
  wire frame_fall = fs_sync_q[2] & ~fs_sync_q[1];
  wire frame_rise = ~fs_sync_q[2] & fs_sync_q[1];
  wire ck_rise    = ~ck_sync_q[2] & ck_sync_q[1];
  wire ck_fall    = ck_sync_q[2] & ~ck_sync_q[1];
  wire sample_edg = rise_edge_q ? ck_rise : ck_fall;
  wire launch_edg = rise_edge_q ? ck_fall : ck_rise;
  // standalone mode gates the clock once a word is complete
  wire shift_ok   = frame_low & ~sw_hold_q & (chain_en_q | ~done_q);
  wire do_shift   = shift_ok & sample_edg;
  wire [15:0] shift_nx = {shift_q[14:0], di_sync_q[1]};
  wire word_end   = ~chain_en_q & do_shift & (count_q == 5'd15);
  wire exec_chain = chain_en_q & frame_rise;
  wire exec_now   = word_end | exec_chain;
  wire [15:0] exec_word = word_end ? shift_nx : shift_q;
  wire [3:0]  cmd = exec_word[`SDCP_CMD_MSB:`SDCP_CMD_LSB];
  wire [11:0] dat = exec_word[`SDCP_DATA_MSB:`SDCP_DATA_LSB] & DATA_MASK;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_sync_q <= 3'h7;
      ck_sync_q <= 3'h7;
      di_sync_q <= 2'h0;
    end else begin
      fs_sync_q <= {fs_sync_q[1:0], frame_n};
      ck_sync_q <= {ck_sync_q[1:0], shift_clk};
      di_sync_q <= {di_sync_q[0], serial_in};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_edge_q    <= 1'b0;
      chain_en_q     <= 1'b1;
      dac_q          <= `SDCP_RST_DAC;
      shift_q        <= `SDCP_RST_SHIFT;
      count_q        <= 5'd0;
      done_q         <= 1'b0;
      dac_update     <= 1'b0;
      chain_data_out <= 1'b0;
      aborts_q       <= 1'b0;
    end else begin
      dac_update <= 1'b0;
      // clear comes first so an abort in the same cycle still wins
      if (psel && penable && pwrite && paddr == `SDCP_APB_STATUS && pwdata[2])
        aborts_q <= 1'b0;
      if (frame_fall) begin
        count_q <= 5'd0;
        done_q  <= 1'b0;
      end else if (do_shift) begin
        shift_q <= shift_nx;
        if (!chain_en_q) begin
          count_q <= count_q + 5'd1;
          if (count_q == 5'd15)
            done_q <= 1'b1;
        end
      end
      // outgoing bit moves on the opposite edge so the next device samples it stable
      if (launch_edg && frame_low && chain_en_q)
        chain_data_out <= shift_q[15];
      if (frame_rise && !chain_en_q && !done_q && count_q != 5'd0)
        aborts_q <= 1'b1;
      if (exec_now) begin
        case (cmd)
          `SDCP_CMD_LOAD: begin
            dac_q      <= dat;
            dac_update <= 1'b1;
          end
          `SDCP_CMD_READBACK: begin
            shift_q        <= {`SDCP_CMD_READBACK, dac_q};
            chain_data_out <= 1'b0;
          end
          `SDCP_CMD_CHAIN_OFF: chain_en_q  <= 1'b0;
          `SDCP_CMD_RISE_EDGE: rise_edge_q <= 1'b1;
          `SDCP_CMD_CLR_ZERO: begin
            dac_q      <= `SDCP_RST_DAC;
            dac_update <= 1'b1;
          end
          `SDCP_CMD_CLR_MID: begin
            dac_q      <= `SDCP_MID_DAC;
            dac_update <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dac_code <= `SDCP_RST_DAC;
    else
      dac_code <= dac_q;
  end

  // apb: zero wait states, software may freeze the shifter for debug
  wire apb_wr = psel & penable & pwrite;
  wire mapped = (paddr == `SDCP_APB_CTRL) | (paddr == `SDCP_APB_STATUS) |
                (paddr == `SDCP_APB_DAC) | (paddr == `SDCP_APB_SHIFT);
  reg [31:0] rd_d;

  always @* begin
    case (paddr)
      `SDCP_APB_CTRL:   rd_d = {31'h00000000, sw_hold_q};
      `SDCP_APB_STATUS: rd_d = {26'h0000000, count_q[4:2] == 3'h4 ? 1'b1 : 1'b0, frame_low,
                                aborts_q, done_q, rise_edge_q, chain_en_q};
      `SDCP_APB_DAC:    rd_d = {20'h00000, dac_q};
      `SDCP_APB_SHIFT:  rd_d = {16'h0000, shift_q};
      default:          rd_d = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_hold_q <= 1'b0;
      prdata    <= 32'h00000000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable)
        prdata <= pwrite ? 32'h00000000 : rd_d;
      if (apb_wr && pready && paddr == `SDCP_APB_CTRL)
        sw_hold_q <= pwdata[0];
    end
  end

endmodule

// ==== sdcp_checker.sv ====
/* assertions on the ports of sdcp_top.
   bound from tb_top; one pclk domain, reset presetn. */
module sdcp_checker (
  input logic        pclk, presetn, frame_n, shift_clk, serial_in, chain_data_out, dac_update,
  input logic        psel, penable, pwrite, pready, pslverr,
  input logic [11:0] dac_code, paddr,
  input logic [31:0] pwdata, prdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no ready after setup");
  property p_once; pready |=> !pready; endproperty
  a_once: assert property (p_once) else $error("ready held");
  property p_unmap; psel && !penable && paddr > 12'h00C |=> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_mapok; psel && !penable && paddr <= 12'h00C && paddr[1:0] == 2'h0 |=> !pslverr; endproperty
  a_mapok: assert property (p_mapok) else $error("mapped refused");
  property p_errz; pslverr |-> prdata == 32'h0; endproperty
  a_errz: assert property (p_errz) else $error("data on error");
  property p_updcode; !$stable(dac_code) |-> $past(dac_update); endproperty
  a_updcode: assert property (p_updcode) else $error("code moved unannounced");
  property p_pulse; dac_update |=> !dac_update; endproperty
  a_pulse: assert property (p_pulse) else $error("update not a pulse");
  property p_idle; frame_n [*8] |-> !dac_update; endproperty
  a_idle: assert property (p_idle) else $error("update while deselected");
  cover property (dac_update);
  cover property (pslverr);
  cover property ($rose(chain_data_out));
endmodule

// ==== sdcp_host.sv ====
/* host serial port model: frame select, shift clock, data, msb first.
   driven by tasks from tb_top; clock stands still outside frames. */
module sdcp_host (
  output logic frame_n, shift_clk, serial_in,
  input  logic chain_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        rise = 0;
  logic [31:0] got = 0;
  initial begin
    frame_n = 1;
    shift_clk = 1;
    serial_in = 0;
  end
  task send(input logic [31:0] w, input int n);
    frame_n = 0;
    #160;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #160 shift_clk = rise;
      #150 got = {got[30:0], chain_data_out};
      #10 shift_clk = !rise;
    end
    #160 frame_n = 1;
    serial_in = !serial_in;
  endtask
endmodule

// ==== tb_top.sv ====
/* testbench for sdcp_top: apb master, host model, queue of dac results.
   needs sdcp_host and sdcp_checker compiled first. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0, dac_code, d, q[$];
  logic [31:0] pwdata = 0, prdata, rd;
  logic        frame_n, shift_clk, serial_in, chain_data_out, dac_update, pready, pslverr;
  int          errors = 0, n_checks = 0;
  always #20 pclk = ~pclk;
  sdcp_top #(.DAC_BITS(12)) DUT (.pclk, .presetn, .frame_n, .shift_clk, .serial_in, .chain_data_out,
    .dac_code, .dac_update, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  sdcp_host host (.frame_n, .shift_clk, .serial_in, .chain_data_out);
  task chk(string s, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (e !== g) begin
      errors++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task apb(logic w, logic [11:0] a, logic [31:0] wd);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task rdc(logic [11:0] a, logic [31:0] m, logic [31:0] e);
    apb(0, a, 0);
    chk("register", e, rd & m);
  endtask
  task tx(logic [31:0] w, int n, int e);
    if (e >= 0) q.push_back(e[11:0]);
    host.send(w, n);
    repeat (12) @(posedge pclk);
  endtask
  always @(posedge pclk) if (dac_update === 1'b1) begin
    @(posedge pclk) #1;
    if (q.size() == 0) chk("spurious update", 0, 1);
    else chk("dac_code", q.pop_front(), dac_code);
  end
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400us errors++;
    complete_run;
  end
  initial begin
    d = $urandom(32'h0B03);
    repeat (5) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    rdc(12'h008, 32'hFFF, 0);
    rdc(12'h004, 32'h3, 1);
    d = $urandom;
    tx({4'h1, d}, 16, d);
    tx({4'h0, ~d}, 16, -1);
    tx({4'h3, ~d}, 16, -1);
    tx({4'h2, 12'h0}, 16, -1);
    rdc(12'h00C, 32'hFFFF, {4'h2, d});
    tx({4'hC, 12'h0}, 16, 12'h800);
    tx({4'hB, 12'hFFF}, 16, 0);
    $display("end of commands");
    tx({4'h7, d, 4'h1, ~d}, 32, {20'h00000, ~d});
    chk("chain out", {4'h7, d}, host.got[15:0]);
    tx({4'hA, 12'h0}, 16, -1);
    host.rise = 1;
    host.shift_clk = 0;
    rdc(12'h004, 32'h3, 3);
    tx({4'h1, d}, 16, d);
    tx({4'h9, 12'h0}, 16, -1);
    rdc(12'h004, 32'h1, 0);
    $display("end of chain");
    tx(32'h15, 8, -1);
    rdc(12'h004, 32'h8, 8);
    tx({4'h1, ~d, 4'hF}, 20, {20'h00000, ~d});
    $display("end of standalone");
    apb(1, 12'h000, 0);
    rdc(12'h000, 32'h1, 0);
    rdc(12'h010, 32'hFFFFFFFF, 0);
    chk("pslverr", 1, err);
    chk("pending", 0, q.size());
    $display("end of registers");
    complete_run;
  end
endmodule
bind sdcp_top sdcp_checker chk_i (.pclk, .presetn, .frame_n, .shift_clk, .serial_in, .chain_data_out,
  .dac_code, .dac_update, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
